/* File: rtl/pdmd_decoder.sv */
// Program and data memory decoder: ROM limit, on-chip data SRAM and external bus steering
// Operation
// (RULE1) On-chip ROM sits from zero upward, up to 16kB, serving fetches inside limit.
// (RULE2) Fetches above the selected limit go out over the multiplexed bus ports.
// (RULE3) Limit codes 0-5 give none, 03FF, 07FF, 0FFF, 1FFF, 3FFF; 6-7 reserved.
// (RULE4) Limit resets to the full 16kB internal space.
// (RULE5) Limit changes only after the timed-access unlock; plain writes are ignored.
// (RULE6) A new limit applies to the very next fetch.
// (RULE7) Software changes the limit only from code whose region stays put.
// (RULE8) External accesses put low address/data on the low port, high address on high.
// (RULE9) External-access pin low sends every fetch off-chip.
// (RULE10) Program-store strobe goes low during external fetches.
// (RULE11) Data SRAM is 1kB, reached only by external-data moves, never executed.
// (RULE12) Enable code 00, the reset default, sends all data moves outside.
// (RULE13) Code 01 maps 0000-03FF to internal SRAM, the rest outside.
// (RULE14) Enable bits are bits 1 and 0 of register C4, writable any time.
// (RULE15) Code 11: SRAM low, FFFC lock byte, other addresses reserved, no bus.
// (RULE16) Lock byte bits 2-0 show programmed lock bits and are read only.
// (RULE17) Changing enable bits never touches SRAM contents.
// (RULE18) A data move to internal SRAM completes in two machine cycles.
// (RULE19) Reserved codes give a defined mapping: no internal ROM, or all outside.
`timescale 1ns/10ps
module pdmd_decoder
    import pdmd_pkg::*;
#(
    parameter int SRAM_WORDS = 1024
) (
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core fetch request
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    input wire logic [7:0] rom_rdata,
    output logic fetch_ext_ff,
    output logic [7:0] fetch_data,
    // Core external-data move request
    input wire logic move_req,
    input wire logic move_wr,
    input wire logic [15:0] move_addr,
    input wire logic [7:0] move_wdata,
    output logic [7:0] move_rdata,
    output logic move_done,
    output logic move_ext_ff,
    // Pins
    input wire logic external_access_n,
    input wire logic [2:0] security_lock_status,
    input wire logic [7:0] low_addr_data_port_in,
    output pdmd_pkg::pdmd_bus_s bus_out
);
    import pdmd_pkg::*;

    // Pin synchronisers; the access pin reads high in reset so early fetches stay internal
    logic ext_acc_s1_ff, ext_acc_s2_ff;
    logic [2:0] lock_s1_ff, lock_s2_ff;
    logic [7:0] port_lo_s1_ff, port_lo_s2_ff;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ext_acc_s1_ff <= 1'b1;
            ext_acc_s2_ff <= 1'b1;
            lock_s1_ff <= 3'h0;
            lock_s2_ff <= 3'h0;
            port_lo_s1_ff <= 8'h00;
            port_lo_s2_ff <= 8'h00;
        end else begin
            ext_acc_s1_ff <= external_access_n;
            ext_acc_s2_ff <= ext_acc_s1_ff;
            lock_s1_ff <= security_lock_status;
            lock_s2_ff <= lock_s1_ff;
            port_lo_s1_ff <= low_addr_data_port_in;
            port_lo_s2_ff <= port_lo_s1_ff;
        end
    end

    // Timed-access unlock: two key writes, then a short window
    logic [1:0] ta_stage_ff;
    logic [1:0] ta_win_ff;
    wire ta_wr = reg_wr && (reg_addr == PDMD_ADDR_TAU);
    wire ta_open = (ta_win_ff != 2'h0);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ta_stage_ff <= 2'h0;
            ta_win_ff <= 2'h0;
        end else if (ta_wr && reg_wdata == PDMD_TA_KEY1) begin
            ta_stage_ff <= 2'h1;
            ta_win_ff <= 2'h0;
        end else if (ta_wr && reg_wdata == PDMD_TA_KEY2 && ta_stage_ff == 2'h1) begin
            ta_stage_ff <= 2'h0;
            ta_win_ff <= PDMD_TA_WIN;
        end else begin
            ta_stage_ff <= reg_wr ? 2'h0 : ta_stage_ff;
            ta_win_ff <= ta_open ? ta_win_ff - 2'h1 : 2'h0;
        end
    end

    // Registers: limit code guarded, enable bits free
    logic [2:0] rom_code_ff;
    logic [1:0] dme_ff;
    wire rls_wr = reg_wr && (reg_addr == PDMD_ADDR_RLS);
    wire pmc_wr = reg_wr && (reg_addr == PDMD_ADDR_PMC);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rom_code_ff <= PDMD_RLS_RST; // see (RULE4)
            dme_ff <= PDMD_PMC_RST[1:0]; // see (RULE12)
        end else begin
            if (rls_wr && ta_open) begin
                rom_code_ff <= reg_wdata[2:0]; // see (RULE5)
            end
            if (pmc_wr) begin
                dme_ff <= {reg_wdata[PDMD_DME_HI_POS], reg_wdata[PDMD_DME_LO_POS]}; // see (RULE14)
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    wire [7:0] rd_mux = (reg_addr == PDMD_ADDR_RLS) ? {5'h00, rom_code_ff} :
                        (reg_addr == PDMD_ADDR_PMC) ? {6'h00, dme_ff} :
                        (reg_addr == PDMD_ADDR_TAU) ? {7'h00, ta_open} : 8'h00;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Fetch steering uses the live code, so a new limit binds the next fetch
    wire [16:0] rom_top = pdmd_rom_top(rom_code_ff); // see (RULE3) (RULE19)
    wire fetch_in_rom = ext_acc_s2_ff && rom_top[16] && (fetch_addr <= rom_top[15:0]); // see (RULE1) (RULE9)
    wire fetch_go_ext = fetch_req && !fetch_in_rom; // see (RULE2) (RULE6)

    // Data move steering; reserved code 10 behaves as all-external
    wire move_low = (move_addr <= PDMD_SRAM_TOP);
    wire sram_on = dme_ff[0];
    wire lock_hit = (dme_ff == 2'b11) && (move_addr == PDMD_LOCK_ADDR);
    pdmd_dst_e move_dst;
    assign move_dst = (sram_on && move_low) ? PDMD_DST_SRAM : // see (RULE13)
                      (dme_ff == 2'b11) ? PDMD_DST_NONE :     // see (RULE15)
                      PDMD_DST_EXT;                           // see (RULE12) (RULE19)

    // Internal move timing: busy counter gives two machine cycles
    logic [3:0] mv_cnt_ff;
    logic mv_busy_ff;
    logic [7:0] mv_data_ff;
    logic [7:0] sram_mem [SRAM_WORDS];
    wire mv_start = move_req && !mv_busy_ff;
    wire [9:0] sram_idx = move_addr[9:0];
    always_ff @(posedge mclk) begin
        if (mv_start && move_dst == PDMD_DST_SRAM && move_wr) begin
            sram_mem[sram_idx] <= move_wdata; // see (RULE11) (RULE17)
        end
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mv_busy_ff <= 1'b0;
            mv_cnt_ff <= 4'h0;
            mv_data_ff <= 8'h00;
        end else if (mv_start) begin
            mv_busy_ff <= 1'b1;
            mv_cnt_ff <= PDMD_INT_MOVE_CYC - 4'h1; // see (RULE18)
            mv_data_ff <= (move_dst == PDMD_DST_SRAM) ? sram_mem[sram_idx] :
                          lock_hit ? {5'h00, lock_s2_ff} : 8'hFF; // see (RULE16)
        end else if (mv_busy_ff) begin
            mv_cnt_ff <= mv_cnt_ff - 4'h1;
            mv_busy_ff <= (mv_cnt_ff != 4'h1);
        end
    end

    // Outputs and external bus, all registered
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fetch_ext_ff <= 1'b0;
            fetch_data <= 8'h00;
            move_ext_ff <= 1'b0;
            move_done <= 1'b0;
            move_rdata <= 8'h00;
            bus_out <= '{low_addr_data: 8'h00, low_oe: 1'b0, high_addr: 8'h00, high_oe: 1'b0,
                         store_strobe_n: 1'b1};
        end else begin
            fetch_ext_ff <= fetch_go_ext;
            fetch_data <= (fetch_req && fetch_in_rom) ? rom_rdata : port_lo_s2_ff;
            move_ext_ff <= mv_start && (move_dst == PDMD_DST_EXT);
            move_done <= mv_busy_ff && (mv_cnt_ff == 4'h1);
            move_rdata <= mv_busy_ff && (mv_cnt_ff == 4'h1) ? mv_data_ff : move_rdata;
            // Low port multiplexes address then data; high port holds upper address
            if (fetch_go_ext) begin
                bus_out.low_addr_data <= fetch_addr[7:0]; // see (RULE8)
                bus_out.high_addr <= fetch_addr[15:8];
                bus_out.low_oe <= 1'b1;
                bus_out.high_oe <= 1'b1;
                bus_out.store_strobe_n <= 1'b0; // see (RULE10)
            end else if (mv_start && move_dst == PDMD_DST_EXT) begin
                bus_out.low_addr_data <= move_addr[7:0]; // see (RULE8)
                bus_out.high_addr <= move_addr[15:8];
                bus_out.low_oe <= 1'b1;
                bus_out.high_oe <= 1'b1;
                bus_out.store_strobe_n <= 1'b1;
            end else if (fetch_ext_ff) begin
                // Data phase: low port released, strobe held so the memory can drive it
                bus_out.low_oe <= 1'b0; // see (RULE8)
                bus_out.high_oe <= 1'b1;
                bus_out.store_strobe_n <= 1'b0; // see (RULE10)
            end else begin
                bus_out.low_oe <= 1'b0;
                bus_out.high_oe <= 1'b0;
                bus_out.store_strobe_n <= 1'b1;
            end
        end
    end

    // Checks
    property p_reset_limit;
        @(posedge mclk) $rose(rstn) |-> rom_code_ff == 3'h5;
    endproperty
    a_reset_limit: assert property (p_reset_limit) else $error("limit not 16kB after reset"); // see (RULE4)

    property p_no_plain_write;
        @(posedge mclk) disable iff (!rstn) (rls_wr && !ta_open) |=> $stable(rom_code_ff);
    endproperty
    a_no_plain_write: assert property (p_no_plain_write) else $error("unprotected limit write took"); // see (RULE5)

    property p_pin_override;
        @(posedge mclk) disable iff (!rstn) (fetch_req && !ext_acc_s2_ff) |=> fetch_ext_ff;
    endproperty
    a_pin_override: assert property (p_pin_override) else $error("fetch internal with pin low"); // see (RULE9)

    property p_above_limit;
        @(posedge mclk) disable iff (!rstn)
            (fetch_req && rom_code_ff == 3'h3 && fetch_addr > 16'h0FFF) |=> fetch_ext_ff;
    endproperty
    a_above_limit: assert property (p_above_limit) else $error("fetch above limit stayed inside"); // see (RULE2)

    property p_inside_limit;
        @(posedge mclk) disable iff (!rstn)
            (fetch_req && ext_acc_s2_ff && rom_code_ff == 3'h5 && fetch_addr <= 16'h3FFF) |=> !fetch_ext_ff;
    endproperty
    a_inside_limit: assert property (p_inside_limit) else $error("fetch inside limit went out"); // see (RULE1)

    property p_strobe;
        @(posedge mclk) disable iff (!rstn) fetch_ext_ff |-> !bus_out.store_strobe_n && bus_out.high_oe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not low on external fetch"); // see (RULE10) (RULE8)

    property p_default_ext;
        @(posedge mclk) disable iff (!rstn) (mv_start && dme_ff == 2'b00) |=> move_ext_ff;
    endproperty
    a_default_ext: assert property (p_default_ext) else $error("move not external under code 00"); // see (RULE12)

    property p_code11_nobus;
        @(posedge mclk) disable iff (!rstn) (mv_start && dme_ff == 2'b11) |=> !move_ext_ff;
    endproperty
    a_code11_nobus: assert property (p_code11_nobus) else $error("bus used under code 11"); // see (RULE15)

    property p_two_cycles;
        @(posedge mclk) disable iff (!rstn) mv_start |-> ##8 move_done;
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("move not done in two machine cycles"); // see (RULE18)

    // Fetch routing and the multiplexed bus
    property p_no_rom_code;
        @(posedge mclk) disable iff (!rstn)
            (fetch_req && (rom_code_ff == 3'h0 || rom_code_ff[2:1] == 2'b11)) |=> fetch_ext_ff;
    endproperty
    a_no_rom_code: assert property (p_no_rom_code) else $error("fetch inside, no ROM"); // see (RULE3) (RULE19)

    property p_code1_limit;
        @(posedge mclk) disable iff (!rstn)
            (fetch_req && rom_code_ff == 3'h1 && fetch_addr > 16'h03FF) |=> fetch_ext_ff;
    endproperty
    a_code1_limit: assert property (p_code1_limit) else $error("fetch above 1kB inside"); // see (RULE3)

    property p_rom_data;
        @(posedge mclk) disable iff (!rstn) (fetch_req && fetch_in_rom) |=> fetch_data == $past(rom_rdata);
    endproperty
    a_rom_data: assert property (p_rom_data) else $error("internal fetch data lost"); // see (RULE1)

    property p_fetch_addr;
        @(posedge mclk) disable iff (!rstn)
            fetch_go_ext |=> {bus_out.high_addr, bus_out.low_addr_data} == $past(fetch_addr);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address not on ports"); // see (RULE8)

    property p_data_phase;
        @(posedge mclk) disable iff (!rstn)
            (fetch_ext_ff && !fetch_go_ext && !(mv_start && move_dst == PDMD_DST_EXT)) |=>
            !bus_out.low_oe && !bus_out.store_strobe_n;
    endproperty
    a_data_phase: assert property (p_data_phase) else $error("no data phase after fetch"); // see (RULE8) (RULE10)

    // Register side: guarded limit, free enable bits
    property p_limit_write;
        @(posedge mclk) disable iff (!rstn)
            (rls_wr && ta_open) |=> {5'h00, rom_code_ff} == ($past(reg_wdata) & 8'h07);
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("guarded limit write lost"); // see (RULE5) (RULE6)

    property p_pmc_write;
        @(posedge mclk) disable iff (!rstn)
            pmc_wr |=> {6'h00, dme_ff} == ($past(reg_wdata) & 8'h03);
    endproperty
    a_pmc_write: assert property (p_pmc_write) else $error("enable bits not written"); // see (RULE14)

    property p_limit_read;
        @(posedge mclk) disable iff (!rstn)
            (reg_rd && reg_addr == PDMD_ADDR_RLS) |=> reg_rdata == {5'h00, $past(rom_code_ff)};
    endproperty
    a_limit_read: assert property (p_limit_read) else $error("limit code read wrong"); // see (RULE3)

    // Data move routing; a reserved code must still give a defined result
    property p_code01_low;
        @(posedge mclk) disable iff (!rstn)
            (mv_start && dme_ff == 2'b01 && move_addr <= 16'h03FF) |=> !move_ext_ff;
    endproperty
    a_code01_low: assert property (p_code01_low) else $error("low move left chip"); // see (RULE13)

    property p_code01_high;
        @(posedge mclk) disable iff (!rstn)
            (mv_start && dme_ff == 2'b01 && move_addr > 16'h03FF) |=> move_ext_ff;
    endproperty
    a_code01_high: assert property (p_code01_high) else $error("high move stayed inside"); // see (RULE13)

    property p_code10_ext;
        @(posedge mclk) disable iff (!rstn) (mv_start && dme_ff == 2'b10) |=> move_ext_ff;
    endproperty
    a_code10_ext: assert property (p_code10_ext) else $error("reserved code move not external"); // see (RULE19)

    property p_move_addr;
        @(posedge mclk) disable iff (!rstn)
            (move_ext_ff && !fetch_ext_ff) |-> {bus_out.high_addr, bus_out.low_addr_data} == $past(move_addr);
    endproperty
    a_move_addr: assert property (p_move_addr) else $error("move address not on ports"); // see (RULE8)

    property p_lock_read;
        @(posedge mclk) disable iff (!rstn)
            (mv_start && lock_hit) |=> mv_data_ff == {5'h00, $past(lock_s2_ff)};
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock byte wrong"); // see (RULE16)

    property p_reserved_ff;
        @(posedge mclk) disable iff (!rstn)
            (mv_start && move_dst == PDMD_DST_NONE && !lock_hit) |=> mv_data_ff == 8'hFF;
    endproperty
    a_reserved_ff: assert property (p_reserved_ff) else $error("reserved read not FF"); // see (RULE15)

    c_ext_fetch: cover property (@(posedge mclk) disable iff (!rstn) fetch_ext_ff);
    c_sram_move: cover property (@(posedge mclk) disable iff (!rstn) mv_start && move_dst == PDMD_DST_SRAM);
    c_lock_read: cover property (@(posedge mclk) disable iff (!rstn) mv_start && lock_hit);
    c_limit_change: cover property (@(posedge mclk) disable iff (!rstn) rls_wr && ta_open);
    c_data_phase: cover property (@(posedge mclk) disable iff (!rstn) fetch_ext_ff ##1 !bus_out.low_oe);
endmodule

/* File: rtl/pdmd_pkg.sv */
// Package for the program and data memory decoder: register map, codes and limits
package pdmd_pkg;
    // Register indexes on the plain register port
    localparam logic [7:0] PDMD_ADDR_PMC = 8'hC4;
    localparam logic [7:0] PDMD_ADDR_RLS = 8'hC2;
    localparam logic [7:0] PDMD_ADDR_TAU = 8'hC7;
    // Field positions
    localparam int PDMD_DME_LO_POS = 0;
    localparam int PDMD_DME_HI_POS = 1;
    // Reset values
    localparam logic [7:0] PDMD_PMC_RST = 8'h00;
    localparam logic [2:0] PDMD_RLS_RST = 3'h5;
    // Timed-access unlock bytes and window length in cycles
    localparam logic [7:0] PDMD_TA_KEY1 = 8'hAA;
    localparam logic [7:0] PDMD_TA_KEY2 = 8'h55;
    localparam logic [1:0] PDMD_TA_WIN = 2'h3;
    // Address limits
    localparam logic [15:0] PDMD_SRAM_TOP = 16'h03FF;
    localparam logic [15:0] PDMD_LOCK_ADDR = 16'hFFFC;
    // Internal moves complete in two machine cycles of four clocks
    localparam int PDMD_CLK_PER_MC = 4;
    localparam logic [3:0] PDMD_INT_MOVE_CYC = 4'(2 * PDMD_CLK_PER_MC);

    typedef enum logic [2:0] {
        PDMD_DST_EXT = 3'b001,
        PDMD_DST_SRAM = 3'b010,
        PDMD_DST_NONE = 3'b100
    } pdmd_dst_e;

    // External bus drive bundle
    typedef struct packed {
        logic [7:0] low_addr_data;
        logic low_oe;
        logic [7:0] high_addr;
        logic high_oe;
        logic store_strobe_n;
    } pdmd_bus_s;

    // Maximum internal program address per limit code; valid flag cleared for none or reserved
    function automatic logic [16:0] pdmd_rom_top(input logic [2:0] code);
        case (code)
            3'h1: pdmd_rom_top = {1'b1, 16'h03FF};
            3'h2: pdmd_rom_top = {1'b1, 16'h07FF};
            3'h3: pdmd_rom_top = {1'b1, 16'h0FFF};
            3'h4: pdmd_rom_top = {1'b1, 16'h1FFF};
            3'h5: pdmd_rom_top = {1'b1, 16'h3FFF};
            default: pdmd_rom_top = {1'b0, 16'h0000};
        endcase
    endfunction
endpackage

/* File: verif/pdmd_ext_mem.sv */
// External program memory model hanging on the multiplexed bus
`timescale 1ns/10ps
module pdmd_ext_mem (
    input wire logic mclk,
    input wire pdmd_pkg::pdmd_bus_s bus_out,
    output logic [7:0] low_addr_data_port_in
);
    import pdmd_pkg::*;
    logic [15:0] addr_ff = 16'h0000;
    logic [7:0] last_ff = 8'h00;
    // Address is latched while the decoder drives both ports
    always @(posedge mclk) begin
        if (bus_out.low_oe && bus_out.high_oe) begin
            addr_ff <= {bus_out.high_addr, bus_out.low_addr_data};
        end
        last_ff <= low_addr_data_port_in;
    end
    // Strobe enables the output; a released port toggles so stale data cannot pass as valid
    assign low_addr_data_port_in = (!bus_out.store_strobe_n && !bus_out.low_oe) ?
        (addr_ff[7:0] ^ addr_ff[15:8]) : ~last_ff;
endmodule

/* File: verif/program_data_memory_decoder_tb_top.sv */
// Self-checking bench for the program and data memory decoder
`timescale 1ns/10ps
module program_data_memory_decoder_tb_top;
    import pdmd_pkg::*;
    typedef struct {string name; logic [31:0] val; logic [31:0] mask;} pdmd_note_s;
    localparam logic [15:0] TOPS [8] = '{16'h0000, 16'h03FF, 16'h07FF, 16'h0FFF, 16'h1FFF, 16'h3FFF,
        16'h0000, 16'h0000};
    localparam logic [7:0] TOP_OK = 8'h3E;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic reg_wr = 1'h0, reg_rd = 1'h0, fetch_req = 1'h0, move_req = 1'h0, move_wr = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rom_rdata = 8'h00, move_wdata = 8'h00;
    logic [15:0] fetch_addr = 16'h0000, move_addr = 16'h0000, sa, lfsr_ff = 16'h0009;
    logic [7:0] reg_rdata, fetch_data, move_rdata, low_in, sd;
    logic external_access_n = 1'h1;
    logic [2:0] lock_bits = 3'h0;
    logic fetch_ext_ff, move_done, move_ext_ff;
    pdmd_bus_s bus_out;
    logic rd_d = 1'h0, fe_d = 1'h0, mv_d = 1'h0;
    logic [7:0] mv_cnt = 8'h00;
    int fails = 0, num_checks = 0, cycles = 0;
    pdmd_note_s exp_q[$];

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    initial begin
        forever #10 mclk = ~mclk;
    end

    pdmd_decoder pdmd_decoder_inst (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .rom_rdata(rom_rdata), .fetch_ext_ff(fetch_ext_ff), .fetch_data(fetch_data), .move_req(move_req),
        .move_wr(move_wr), .move_addr(move_addr), .move_wdata(move_wdata), .move_rdata(move_rdata),
        .move_done(move_done), .move_ext_ff(move_ext_ff), .external_access_n(external_access_n),
        .security_lock_status(lock_bits), .low_addr_data_port_in(low_in), .bus_out(bus_out));
    pdmd_ext_mem pdmd_ext_mem_inst (.mclk(mclk), .bus_out(bus_out), .low_addr_data_port_in(low_in));

    // Request history tells the monitor which result is due; also the hang guard
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        fe_d <= fetch_req;
        mv_d <= move_req;
        mv_cnt <= move_req ? 8'h01 : mv_cnt + 8'h01;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            finish_test();
        end
    end

    // Monitor samples at the falling edge, where registered outputs have settled
    always @(negedge mclk) begin
        logic [31:0] obs;
        pdmd_note_s n;
        obs = 32'h0;
        if (rd_d) obs = {24'h0, reg_rdata};
        if (fe_d) obs = {fetch_ext_ff, bus_out.store_strobe_n, bus_out.high_oe, bus_out.low_oe, 4'h0,
            bus_out.high_addr, bus_out.low_addr_data, fetch_data};
        if (mv_d) obs = {move_ext_ff, bus_out.high_oe, bus_out.low_oe, 5'h0, bus_out.high_addr,
            bus_out.low_addr_data, 8'h0};
        if (move_done === 1'h1) obs = {mv_cnt, 16'h0, move_rdata};
        if (rd_d || fe_d || mv_d || move_done === 1'h1) begin
            num_checks++;
            if (exp_q.size() == 0) begin
                fails++;
                $display("BAD unexpected result expected none seen %h", obs);
            end else begin
                n = exp_q.pop_front();
                if ((obs & n.mask) !== n.val) begin
                    fails++;
                    $display("BAD %s expected %h seen %h", n.name, n.val, obs & n.mask);
                end
            end
        end
    end

    task automatic note(input string nm, input logic [31:0] v, input logic [31:0] m);
        exp_q.push_back(pdmd_note_s'{nm, v & m, m});
    endtask

    // One write or read; for a read d is the expected byte
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        if (!wr) note("reg_rdata", {24'h0, d}, 32'h000000FF);
        @(posedge mclk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
    endtask

    // Unlock keys and limit write on three back-to-back cycles; no fetch in flight meanwhile
    task automatic set_limit(input logic [2:0] c);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= PDMD_ADDR_TAU;
        reg_wdata <= PDMD_TA_KEY1;
        @(posedge mclk);
        reg_wdata <= PDMD_TA_KEY2;
        @(posedge mclk);
        reg_addr <= PDMD_ADDR_RLS;
        reg_wdata <= {5'h0, c};
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask

    task automatic fetch(input logic [15:0] a, input logic ext);
        lfsr_ff = lfsr(lfsr_ff);
        @(posedge mclk);
        fetch_req <= 1'h1;
        fetch_addr <= a;
        rom_rdata <= lfsr_ff[7:0];
        note("fetch", ext ? {8'hB0, a, 8'h0} : {24'h400000, lfsr_ff[7:0]}, ext ? 32'hF0FFFF00 : 32'hC00000FF);
        @(posedge mclk);
        fetch_req <= 1'h0;
    endtask

    // Route is checked one cycle after take, completion exactly two machine cycles later
    task automatic move(input logic w, input logic [15:0] a, input logic [7:0] d, input logic ext,
        input logic [7:0] rd);
        @(posedge mclk);
        move_req <= 1'h1;
        move_wr <= w;
        move_addr <= a;
        move_wdata <= d;
        note("move_route", ext ? {8'hE0, a, 8'h0} : 32'h0, ext ? 32'hE0FFFF00 : 32'hE0000000);
        note("move_done", {8'h08, 16'h0, rd}, (w || ext) ? 32'hFF000000 : 32'hFF0000FF);
        @(posedge mclk);
        move_req <= 1'h0;
        repeat (9) @(posedge mclk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'h1;
        lock_bits <= 3'h5;
        repeat (3) @(posedge mclk);
        reg_op(1'h0, PDMD_ADDR_RLS, 8'h05);
        reg_op(1'h0, PDMD_ADDR_PMC, 8'h00);
        fetch(16'h3FFF, 1'h0);
        fetch(16'h4000, 1'h1);
        reg_op(1'h1, PDMD_ADDR_RLS, 8'h00);
        fetch(16'h0000, 1'h0);
        $display("test reset_and_protect done");
        for (int c = 0; c < 8; c++) begin
            set_limit(3'(c));
            reg_op(1'h0, PDMD_ADDR_RLS, 8'(c));
            fetch(TOPS[c], !TOP_OK[c]);
            fetch(TOPS[c] + 16'h0001, 1'h1);
        end
        $display("test limit_codes done");
        set_limit(3'h5);
        external_access_n <= 1'h0;
        repeat (4) @(posedge mclk);
        fetch(16'h0123, 1'h1);
        external_access_n <= 1'h1;
        repeat (4) @(posedge mclk);
        fetch(16'h0123, 1'h0);
        $display("test access_pin done");
        lfsr_ff = lfsr(lfsr_ff);
        sa = {6'h00, lfsr_ff[9:0]};
        sd = lfsr_ff[15:8];
        move(1'h1, 16'h0010, 8'h5A, 1'h1, 8'h00);
        reg_op(1'h1, PDMD_ADDR_PMC, 8'h01);
        move(1'h1, sa, sd, 1'h0, 8'h00);
        move(1'h0, sa, 8'h00, 1'h0, sd);
        move(1'h0, 16'h0400, 8'h00, 1'h1, 8'h00);
        reg_op(1'h1, PDMD_ADDR_PMC, 8'h02);
        move(1'h0, sa, 8'h00, 1'h1, 8'h00);
        reg_op(1'h1, PDMD_ADDR_PMC, 8'h03);
        move(1'h0, PDMD_LOCK_ADDR, 8'h00, 1'h0, 8'h05);
        move(1'h1, PDMD_LOCK_ADDR, 8'hFA, 1'h0, 8'h00);
        move(1'h0, PDMD_LOCK_ADDR, 8'h00, 1'h0, 8'h05);
        move(1'h0, 16'hFFFB, 8'h00, 1'h0, 8'hFF);
        move(1'h0, 16'hFFFD, 8'h00, 1'h0, 8'hFF);
        move(1'h0, sa, 8'h00, 1'h0, sd);
        reg_op(1'h1, 8'hA5, 8'hFF);
        reg_op(1'h0, PDMD_ADDR_PMC, 8'h03);
        $display("test data_moves done");
        repeat (3) @(posedge mclk);
        if (exp_q.size() != 0) begin
            fails++;
            $display("BAD pending results expected 0 seen %0d", exp_q.size());
        end
        finish_test();
    end
endmodule
